// ### omc_pkg.sv
// Package: offsets, fields, reset values and modes of the operating mode controller
package omc_pkg;

  // ----------------------------------------
  // Register offsets
  // ----------------------------------------
  localparam logic [3:0] ADDR_CLOCK_MODE = 4'h0;
  localparam logic [3:0] ADDR_AUX_FLAGS  = 4'h1;
  localparam logic [3:0] ADDR_PWR_STATUS = 4'h2;
  localparam logic [3:0] ADDR_CLK_STATUS = 4'h3;

  // ----------------------------------------
  // Field positions
  // ----------------------------------------
  localparam int CM_DIV_LSB     = 5;
  localparam int CM_LOW_READY   = 3;
  localparam int CM_HIGH_READY  = 2;
  localparam int CM_IDLE_EN     = 1;
  localparam int CM_HIGH_SEL    = 0;
  localparam int AUX_CLOCK_KEEP = 7;
  localparam int AUX_RESERVED3  = 3;
  localparam int AUX_LV_FLAG    = 2;
  localparam int AUX_WD_FLAG    = 0;
  localparam int PS_POWER_DOWN  = 1;
  localparam int PS_TIMEOUT     = 0;

  // ----------------------------------------
  // Reset values
  // ----------------------------------------
  localparam logic [2:0] RST_DIV_SEL  = 3'h0;
  localparam logic       RST_IDLE_EN  = 1'b1;
  localparam logic       RST_HIGH_SEL = 1'b1;

  // ----------------------------------------
  // Divider and timing constants
  // ----------------------------------------
  localparam logic [2:0] DIV_LOW_MAX     = 3'h1;
  localparam int         DIV_WIDTH       = 6;
  localparam logic [1:0] LOW_READY_EDGES = 2'h2;
  localparam logic [3:0] HIGH_SETTLE     = 4'hF;

  // ----------------------------------------
  // Operating modes
  // ----------------------------------------
  typedef enum logic [5:0] {
    OMC_NORMAL    = 6'h01,
    OMC_SLOW      = 6'h02,
    OMC_FULL_STOP = 6'h04,
    OMC_STOP_WD   = 6'h08,
    OMC_IDLE_OFF  = 6'h10,
    OMC_IDLE_ON   = 6'h20
  } omc_mode_t;

endpackage

// ### omc_sel_if.sv
// Interface: clock selection request and oscillator status between modules
`timescale 1ns/100ps
`default_nettype none
interface omc_sel_if;
  logic       high_sel;
  logic [2:0] div_sel;
  logic       high_run;
  logic       sys_tick;
  logic       tap16;
  logic       tap64;
  logic       high_ready;

  modport ctrl (output high_sel, output div_sel, output high_run,
                input sys_tick, input tap16, input tap64, input high_ready);
  modport gen  (input high_sel, input div_sel, input high_run,
                output sys_tick, output tap16, output tap64, output high_ready);
endinterface
`default_nettype wire

// ### omc_clk_gen.sv
// Clock enable generator: high-speed divider taps and selected system tick
`timescale 1ns/100ps
`default_nettype none
module omc_clk_gen (
  input  wire logic clk,
  input  wire logic nrst,
  input  wire logic low_tick,
  omc_sel_if.gen    sel
);

  typedef struct packed {
    logic [omc_pkg::DIV_WIDTH-1:0] div;
    logic [3:0]                    settle;
    logic                          ready;
    logic                          tick;
    logic                          t16;
    logic                          t64;
  } omc_gen_t;

  omc_gen_t r;
  omc_gen_t next_r;
  logic [omc_pkg::DIV_WIDTH-1:0] next_div;
  logic                          div_tick;

  // ----------------------------------------
  // Divider and settle counter
  // ----------------------------------------
  always_comb begin
    next_r   = r;
    next_div = r.div + 1'b1;
    div_tick = 1'b0;
    unique case (sel.div_sel)
      3'h2:    div_tick = (r.div[5:0] == 6'h3F);
      3'h3:    div_tick = (r.div[4:0] == 5'h1F);
      3'h4:    div_tick = (r.div[3:0] == 4'hF);
      3'h5:    div_tick = (r.div[2:0] == 3'h7);
      3'h6:    div_tick = (r.div[1:0] == 2'h3);
      3'h7:    div_tick = r.div[0];
      default: div_tick = 1'b0;
    endcase
    if (sel.high_run) begin
      next_r.div = next_div;
      if (!r.ready) begin
        next_r.settle = r.settle + 1'b1;
        next_r.ready  = (r.settle == omc_pkg::HIGH_SETTLE);
      end
    end else begin
      next_r.div    = '0;
      next_r.settle = '0;
      next_r.ready  = 1'b0;
    end
    next_r.t16 = sel.high_run && (r.div[3:0] == 4'hF);
    next_r.t64 = sel.high_run && (r.div[5:0] == 6'h3F);
    if (sel.high_sel) begin
      next_r.tick = sel.high_run;
    end else if (sel.div_sel <= omc_pkg::DIV_LOW_MAX) begin
      next_r.tick = low_tick;
    end else begin
      next_r.tick = sel.high_run && div_tick;
    end
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign sel.sys_tick   = r.tick;
  assign sel.tap16      = r.t16;
  assign sel.tap64      = r.t64;
  assign sel.high_ready = r.ready;

endmodule // omc_clk_gen
`default_nettype wire

// ### omc_wake_sync.sv
// Two-stage synchroniser bank for pin-level inputs
`timescale 1ns/100ps
`default_nettype none
module omc_wake_sync #(
  parameter int W = 4
) (
  input  wire logic         clk,
  input  wire logic         nrst,
  input  wire logic [W-1:0] din,
  output logic      [W-1:0] dout
);

  typedef struct packed {
    logic [W-1:0] s1;
    logic [W-1:0] s2;
  } omc_sync_t;

  omc_sync_t r;
  omc_sync_t next_r;

  // ----------------------------------------
  // Synchroniser stages
  // ----------------------------------------
  always_comb begin
    next_r    = r;
    next_r.s1 = din;
    next_r.s2 = r.s1;
  end

  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r <= '0;
    end else begin
      r <= next_r;
    end
  end

  assign dout = r.s2;

endmodule // omc_wake_sync
`default_nettype wire

// ### omc_mode_ctrl.sv
// Operating mode controller: clock selection, halt modes and auxiliary flags
//
// Implementation choices: the strobed register port and the register addresses.
`timescale 1ns/100ps
`default_nettype none
module omc_mode_ctrl (
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [3:0] addr,
  input  wire logic [7:0] wdata,
  input  wire logic       wr_stb,
  input  wire logic       rd_stb,
  output logic      [7:0] rdata,
  input  wire logic       halt_exec,
  input  wire logic       watchdog_enable,
  input  wire logic       watchdog_bad_code,
  input  wire logic       low_voltage_reset,
  input  wire logic       watchdog_overflow,
  input  wire logic       watchdog_clear_instr,
  input  wire logic       irq_request,
  input  wire logic [3:0] wake_pins,
  input  wire logic [3:0] wake_pin_enable,
  input  wire logic       low_osc_tick,
  output logic            cpu_run,
  output logic            sys_clk_en,
  output logic            timebase_clk_en,
  output logic            watchdog_clk_en,
  output logic            watchdog_counter_clear,
  output logic            high_osc_run,
  output logic            tap16_en,
  output logic            tap64_en,
  output logic            state_hold,
  output logic            wake_reset
);

  typedef struct packed {
    logic [2:0]        div_sel;
    logic              idle_enable;
    logic              high_clock_select;
    logic              low_osc_ready;
    logic [1:0]        low_cnt;
    logic              idle_clock_keep;
    logic              reserved_bit_three;
    logic              low_voltage_reset_flag;
    logic              watchdog_ctrl_reset_flag;
    logic              power_down_flag;
    logic              watchdog_timeout_flag;
    omc_pkg::omc_mode_t mode;
    logic [3:0]        pins_prev;
    logic [7:0]        rdata;
    logic              cpu_run;
    logic              sys_en;
    logic              tb_en;
    logic              wd_en;
    logic              wd_clr;
    logic              high_run;
    logic              t16;
    logic              t64;
    logic              hold;
    logic              wake_rst;
  } omc_state_t;

  omc_state_t r;
  omc_state_t next_r;
  omc_sel_if  sel ();
  logic [3:0] pins_sync;
  logic       lp_mode;
  logic       pin_fall;
  logic       wake;
  logic       low_sel;

  // ----------------------------------------
  // Helpers
  // ----------------------------------------
  function automatic logic omc_uses_low(input logic hs, input logic [2:0] ds);
    return !hs && (ds <= omc_pkg::DIV_LOW_MAX);
  endfunction

  omc_wake_sync #(
    .W (4)
  ) u_sync (
    .clk  (clk),
    .nrst (nrst),
    .din  (wake_pins),
    .dout (pins_sync)
  );

  omc_clk_gen u_gen (
    .clk      (clk),
    .nrst     (nrst),
    .low_tick (low_osc_tick),
    .sel      (sel.gen)
  );

  assign sel.high_sel = r.high_clock_select;
  assign sel.div_sel  = r.div_sel;
  assign sel.high_run = r.high_run;

  // ----------------------------------------
  // Next-state logic
  // ----------------------------------------
  always_comb begin
    next_r    = r;
    low_sel   = omc_uses_low(r.high_clock_select, r.div_sel);
    lp_mode   = (r.mode != omc_pkg::OMC_NORMAL) && (r.mode != omc_pkg::OMC_SLOW);
    pin_fall  = |(r.pins_prev & ~pins_sync & wake_pin_enable);
    wake      = pin_fall || irq_request || watchdog_overflow;
    next_r.pins_prev = pins_sync;
    next_r.wd_clr    = 1'b0;
    next_r.wake_rst  = 1'b0;

    // Register writes
    if (wr_stb && !lp_mode) begin
      unique case (addr)
        omc_pkg::ADDR_CLOCK_MODE: begin
          next_r.div_sel           = wdata[omc_pkg::CM_DIV_LSB +: 3];
          next_r.idle_enable       = wdata[omc_pkg::CM_IDLE_EN];
          next_r.high_clock_select = wdata[omc_pkg::CM_HIGH_SEL];
        end
        omc_pkg::ADDR_AUX_FLAGS: begin
          next_r.idle_clock_keep    = wdata[omc_pkg::AUX_CLOCK_KEEP];
          next_r.reserved_bit_three = wdata[omc_pkg::AUX_RESERVED3];
          if (!wdata[omc_pkg::AUX_LV_FLAG]) begin
            next_r.low_voltage_reset_flag = 1'b0;
          end
          if (!wdata[omc_pkg::AUX_WD_FLAG]) begin
            next_r.watchdog_ctrl_reset_flag = 1'b0;
          end
        end
        default: begin
        end
      endcase
    end
    if (watchdog_bad_code) begin
      next_r.watchdog_ctrl_reset_flag = 1'b1;
    end
    if (low_voltage_reset) begin
      next_r.low_voltage_reset_flag = 1'b1;
    end
    if (watchdog_clear_instr) begin
      next_r.power_down_flag = 1'b0;
    end
    if (watchdog_overflow) begin
      next_r.watchdog_timeout_flag = 1'b1;
    end

    // Halt handling and wake-up
    unique case (r.mode)
      omc_pkg::OMC_NORMAL, omc_pkg::OMC_SLOW: begin
        if (halt_exec) begin
          next_r.power_down_flag       = 1'b1;
          next_r.watchdog_timeout_flag = watchdog_overflow;
          next_r.wd_clr                = 1'b1;
          if (r.idle_enable) begin
            next_r.mode = r.idle_clock_keep ? omc_pkg::OMC_IDLE_ON : omc_pkg::OMC_IDLE_OFF;
          end else begin
            next_r.mode = watchdog_enable ? omc_pkg::OMC_STOP_WD : omc_pkg::OMC_FULL_STOP;
          end
        end else begin
          next_r.mode = low_sel ? omc_pkg::OMC_SLOW : omc_pkg::OMC_NORMAL;
        end
      end
      default: begin
        if (wake) begin
          next_r.mode     = low_sel ? omc_pkg::OMC_SLOW : omc_pkg::OMC_NORMAL;
          next_r.wake_rst = watchdog_overflow;
        end
      end
    endcase

    // Clock gating per mode
    unique case (next_r.mode)
      omc_pkg::OMC_FULL_STOP: begin
        next_r.sys_en = 1'b0;
        next_r.tb_en  = 1'b0;
        next_r.wd_en  = 1'b0;
      end
      omc_pkg::OMC_STOP_WD: begin
        next_r.sys_en = 1'b0;
        next_r.tb_en  = 1'b0;
        next_r.wd_en  = watchdog_enable;
      end
      omc_pkg::OMC_IDLE_OFF: begin
        next_r.sys_en = 1'b0;
        next_r.tb_en  = 1'b1;
        next_r.wd_en  = watchdog_enable;
      end
      omc_pkg::OMC_IDLE_ON: begin
        next_r.sys_en = 1'b1;
        next_r.tb_en  = 1'b1;
        next_r.wd_en  = watchdog_enable;
      end
      default: begin
        next_r.sys_en = 1'b1;
        next_r.tb_en  = 1'b1;
        next_r.wd_en  = watchdog_enable;
      end
    endcase
    next_r.sys_en  = next_r.sys_en && sel.sys_tick;
    next_r.cpu_run = (next_r.mode == omc_pkg::OMC_NORMAL) || (next_r.mode == omc_pkg::OMC_SLOW);
    next_r.hold    = !next_r.cpu_run;

    // High oscillator runs unless slow source chosen or clock stopped
    next_r.high_run = !low_sel && (next_r.mode != omc_pkg::OMC_FULL_STOP) &&
                      (next_r.mode != omc_pkg::OMC_STOP_WD) &&
                      (next_r.mode != omc_pkg::OMC_IDLE_OFF);
    next_r.t16 = sel.tap16 && next_r.high_run;
    next_r.t64 = sel.tap64 && next_r.high_run;

    // Low oscillator ready after wake-up
    if (next_r.mode == omc_pkg::OMC_FULL_STOP) begin
      next_r.low_osc_ready = 1'b0;
      next_r.low_cnt       = '0;
    end else if (!r.low_osc_ready && low_osc_tick) begin
      next_r.low_cnt = r.low_cnt + 1'b1;
      if (r.low_cnt + 1'b1 >= omc_pkg::LOW_READY_EDGES - 1'b1) begin
        next_r.low_osc_ready = 1'b1;
      end
    end

    // Read data one cycle after the strobe
    next_r.rdata = '0;
    if (rd_stb) begin
      unique case (addr)
        omc_pkg::ADDR_CLOCK_MODE: begin
          next_r.rdata = {r.div_sel, 1'b0, r.low_osc_ready, sel.high_ready,
                          r.idle_enable, r.high_clock_select};
        end
        omc_pkg::ADDR_AUX_FLAGS: begin
          next_r.rdata = {r.idle_clock_keep, 3'h0, r.reserved_bit_three,
                          r.low_voltage_reset_flag, 1'b0, r.watchdog_ctrl_reset_flag};
        end
        omc_pkg::ADDR_PWR_STATUS: begin
          next_r.rdata = {6'h00, r.power_down_flag, r.watchdog_timeout_flag};
        end
        omc_pkg::ADDR_CLK_STATUS: begin
          next_r.rdata = {2'h0, r.mode};
        end
        default: begin
          next_r.rdata = 8'h00;
        end
      endcase
    end
  end

  // ----------------------------------------
  // State register
  // ----------------------------------------
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      r                          <= '0;
      r.div_sel                  <= omc_pkg::RST_DIV_SEL;
      r.idle_enable              <= omc_pkg::RST_IDLE_EN;
      r.high_clock_select        <= omc_pkg::RST_HIGH_SEL;
      r.mode                     <= omc_pkg::OMC_NORMAL;
      r.cpu_run                  <= 1'b1;
      r.sys_en                   <= 1'b1;
      r.tb_en                    <= 1'b1;
      r.high_run                 <= 1'b1;
    end else begin
      r <= next_r;
    end
  end

  assign rdata                  = r.rdata;
  assign cpu_run                = r.cpu_run;
  assign sys_clk_en             = r.sys_en;
  assign timebase_clk_en        = r.tb_en;
  assign watchdog_clk_en        = r.wd_en;
  assign watchdog_counter_clear = r.wd_clr;
  assign high_osc_run           = r.high_run;
  assign tap16_en               = r.t16;
  assign tap64_en               = r.t64;
  assign state_hold             = r.hold;
  assign wake_reset             = r.wake_rst;

endmodule // omc_mode_ctrl
`default_nettype wire

// ### omc_mode_ctrl_props.sv
// Checker: port-level properties of the operating mode controller
`timescale 1ns/100ps
`default_nettype none
module omc_mode_ctrl_props (
  input wire logic       clk,
  input wire logic       nrst,
  input wire logic [3:0] addr,
  input wire logic [7:0] wdata,
  input wire logic       wr_stb,
  input wire logic       rd_stb,
  input wire logic [7:0] rdata,
  input wire logic       halt_exec,
  input wire logic       watchdog_enable,
  input wire logic       watchdog_overflow,
  input wire logic       irq_request,
  input wire logic       cpu_run,
  input wire logic       sys_clk_en,
  input wire logic       timebase_clk_en,
  input wire logic       watchdog_clk_en,
  input wire logic       watchdog_counter_clear,
  input wire logic       high_osc_run,
  input wire logic       tap16_en,
  input wire logic       tap64_en,
  input wire logic       state_hold,
  input wire logic       wake_reset
);
  // ----------------------------------------
  // Shadow of idle and keep bits
  // ----------------------------------------
  logic idle_sh;
  logic keep_sh;
  logic go;
  always_ff @(posedge clk or negedge nrst) begin
    if (!nrst) begin
      idle_sh <= 1'b1;
      keep_sh <= 1'b0;
    end else if (wr_stb && cpu_run) begin
      if (addr == omc_pkg::ADDR_CLOCK_MODE) idle_sh <= wdata[1];
      if (addr == omc_pkg::ADDR_AUX_FLAGS) keep_sh <= wdata[7];
    end
  end
  assign go = halt_exec && cpu_run;

  // ----------------------------------------
  // Properties
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!nrst);

  a_full_stop_clocks: assert property (go && !idle_sh && !watchdog_enable |=>
    !cpu_run && !sys_clk_en && !watchdog_clk_en && !timebase_clk_en) else $error("full stop clocks");
  a_stop_wd_runs: assert property (go && !idle_sh && watchdog_enable |=>
    !cpu_run && !sys_clk_en && !timebase_clk_en && watchdog_clk_en) else $error("stop with watchdog");
  a_idle_off_clocks: assert property (go && idle_sh && !keep_sh |=>
    !cpu_run && !sys_clk_en && timebase_clk_en) else $error("idle clock off");
  a_idle_on_clocks: assert property (go && idle_sh && keep_sh |=>
    !cpu_run && timebase_clk_en) else $error("idle clock on");
  a_halt_clear_pulse: assert property (go |=> watchdog_counter_clear ##1 !watchdog_counter_clear)
    else $error("watchdog clear pulse");
  a_state_held: assert property (state_hold == !cpu_run) else $error("state hold");
  a_irq_wakes: assert property (irq_request && !cpu_run |=> cpu_run) else $error("irq wake");
  a_overflow_wakes: assert property (watchdog_overflow && !cpu_run |-> ##[1:2] wake_reset)
    else $error("overflow wake");
  a_slow_osc_off: assert property (wr_stb && cpu_run && addr == omc_pkg::ADDR_CLOCK_MODE
    && !wdata[0] && wdata[7:5] <= 3'h1 |-> ##[1:300] !high_osc_run) else $error("high osc stays on");
  a_taps_quiet: assert property (!$past(high_osc_run) && !high_osc_run |-> !tap16_en && !tap64_en)
    else $error("taps run");
  a_aux_unused_zero: assert property (rd_stb && addr == omc_pkg::ADDR_AUX_FLAGS |=>
    rdata[6:4] == 3'h0 && !rdata[1]) else $error("aux unused bits");
  a_rdata_idle_zero: assert property (!rd_stb |=> rdata == 8'h00) else $error("rdata outside read");

  c_full_stop: cover property (go && !idle_sh && !watchdog_enable);
  c_idle_on: cover property (go && idle_sh && keep_sh);
  c_irq_wake: cover property (irq_request && !cpu_run);
endmodule // omc_mode_ctrl_props

bind omc_mode_ctrl omc_mode_ctrl_props props_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata),
  .wr_stb(wr_stb), .rd_stb(rd_stb), .rdata(rdata), .halt_exec(halt_exec), .watchdog_enable(watchdog_enable),
  .watchdog_overflow(watchdog_overflow), .irq_request(irq_request), .cpu_run(cpu_run), .sys_clk_en(sys_clk_en),
  .timebase_clk_en(timebase_clk_en), .watchdog_clk_en(watchdog_clk_en),
  .watchdog_counter_clear(watchdog_counter_clear), .high_osc_run(high_osc_run), .tap16_en(tap16_en),
  .tap64_en(tap64_en), .state_hold(state_hold), .wake_reset(wake_reset));
`default_nettype wire

// ### omc_mode_ctrl_tb_top.sv
// Testbench: register, halt, wake and clock switching tests
`timescale 1ns/100ps
`default_nettype none
module omc_mode_ctrl_tb_top;
  logic       clk = 1'b0, nrst = 1'b0;
  logic [3:0] addr = 4'h0, wake_pins = 4'hF, wake_pin_enable = 4'h1;
  logic [7:0] wdata = 8'h00;
  logic       wr_stb = 1'b0, rd_stb = 1'b0, halt_exec = 1'b0, watchdog_enable = 1'b0;
  logic       watchdog_bad_code = 1'b0, low_voltage_reset = 1'b0, watchdog_overflow = 1'b0;
  logic       watchdog_clear_instr = 1'b0, irq_request = 1'b0, low_osc_tick = 1'b0;
  logic [2:0] tick_cnt = 3'h0;
  logic [7:0] rdata;
  logic       cpu_run, sys_clk_en, timebase_clk_en, watchdog_clk_en, watchdog_counter_clear;
  logic       high_osc_run, tap16_en, tap64_en, state_hold, wake_reset;
  logic [1:0] mon;
  int         err_total = 0, checks = 0;

  omc_mode_ctrl dut_u (.clk(clk), .nrst(nrst), .addr(addr), .wdata(wdata), .wr_stb(wr_stb), .rd_stb(rd_stb),
    .rdata(rdata), .halt_exec(halt_exec), .watchdog_enable(watchdog_enable),
    .watchdog_bad_code(watchdog_bad_code), .low_voltage_reset(low_voltage_reset),
    .watchdog_overflow(watchdog_overflow), .watchdog_clear_instr(watchdog_clear_instr),
    .irq_request(irq_request), .wake_pins(wake_pins), .wake_pin_enable(wake_pin_enable),
    .low_osc_tick(low_osc_tick), .cpu_run(cpu_run), .sys_clk_en(sys_clk_en),
    .timebase_clk_en(timebase_clk_en), .watchdog_clk_en(watchdog_clk_en),
    .watchdog_counter_clear(watchdog_counter_clear), .high_osc_run(high_osc_run), .tap16_en(tap16_en),
    .tap64_en(tap64_en), .state_hold(state_hold), .wake_reset(wake_reset));

  assign mon = {high_osc_run, cpu_run};
  always #5 clk = ~clk;
  always @(posedge clk) begin
    tick_cnt <= tick_cnt + 3'h1;
    low_osc_tick <= (tick_cnt == 3'h7);
  end

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic results;
    $display("checks %0d mismatches %0d", checks, err_total);
    if (err_total == 0 && checks > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input string n, input logic [7:0] e, input logic [7:0] g);
    checks++;
    if (g !== e) begin
      err_total++;
      $display("MISMATCH %s expected %h seen %h", n, e, g);
    end
  endtask
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge clk);
    addr <= a;
    wdata <= d;
    wr_stb <= 1'b1;
    @(posedge clk);
    wr_stb <= 1'b0;
  endtask
  task automatic rd(input logic [3:0] a, input logic [7:0] m, input logic [7:0] e, input string n);
    @(posedge clk);
    addr <= a;
    rd_stb <= 1'b1;
    @(posedge clk);
    rd_stb <= 1'b0;
    #1;
    chk(n, e, rdata & m);
  endtask
  task automatic wait_lvl(input int k, input logic v);
    int n;
    n = 0;
    while (mon[k] !== v && n < 300) begin
      @(posedge clk);
      #1;
      n++;
    end
    if (n == 300) begin
      chk("wait", {7'h00, v}, {7'h00, mon[k]});
      results();
    end
  endtask

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (6) @(posedge clk);
    nrst <= 1'b1;
    repeat (30) @(posedge clk);
    rd(omc_pkg::ADDR_CLOCK_MODE, 8'hF7, 8'h07, "mode_reset");
    rd(omc_pkg::ADDR_AUX_FLAGS, 8'hFF, 8'h00, "aux_reset");
    $display("test reset done");
    wr(omc_pkg::ADDR_AUX_FLAGS, 8'hFF);
    rd(omc_pkg::ADDR_AUX_FLAGS, 8'hFF, 8'h88, "aux_set_ones");
    @(posedge clk);
    low_voltage_reset <= 1'b1;
    watchdog_bad_code <= 1'b1;
    @(posedge clk);
    low_voltage_reset <= 1'b0;
    watchdog_bad_code <= 1'b0;
    rd(omc_pkg::ADDR_AUX_FLAGS, 8'hFF, 8'h8D, "aux_flags_set");
    wr(omc_pkg::ADDR_AUX_FLAGS, 8'h89);
    rd(omc_pkg::ADDR_AUX_FLAGS, 8'hFF, 8'h89, "aux_lv_clear");
    wr(omc_pkg::ADDR_AUX_FLAGS, 8'h00);
    rd(omc_pkg::ADDR_AUX_FLAGS, 8'hFF, 8'h00, "aux_wd_clear");
    wr(4'hF, 8'hFF);
    rd(4'hF, 8'hFF, 8'h00, "unmapped");
    $display("test aux done");
    for (int i = 0; i < 4; i++) begin
      wr(omc_pkg::ADDR_CLOCK_MODE, {6'h00, i[1], 1'b1});
      wr(omc_pkg::ADDR_AUX_FLAGS, {i[0], 7'h00});
      watchdog_enable <= (i != 0);
      @(posedge clk);
      halt_exec <= 1'b1;
      @(posedge clk);
      halt_exec <= 1'b0;
      #1;
      chk("cpu_run", 8'h00, {7'h00, cpu_run});
      chk("wd_clear", 8'h01, {7'h00, watchdog_counter_clear});
      chk("timebase", {7'h00, i[1]}, {7'h00, timebase_clk_en});
      chk("wd_clk", {7'h00, i != 0}, {7'h00, watchdog_clk_en});
      rd(omc_pkg::ADDR_PWR_STATUS, 8'hFF, 8'h02, "status_halt");
      rd(omc_pkg::ADDR_CLK_STATUS, 8'hFF, 8'(omc_pkg::OMC_FULL_STOP) << i, "halt_mode");
      wr(omc_pkg::ADDR_AUX_FLAGS, 8'h08);
      if (i == 1) wake_pins <= 4'hE;
      else if (i == 2) watchdog_overflow <= 1'b1;
      else irq_request <= 1'b1;
      @(posedge clk);
      watchdog_overflow <= 1'b0;
      wait_lvl(0, 1'b1);
      irq_request <= 1'b0;
      wake_pins <= 4'hF;
      rd(omc_pkg::ADDR_AUX_FLAGS, 8'hFF, {i[0], 7'h00}, "aux_kept");
      rd(omc_pkg::ADDR_PWR_STATUS, 8'hFF, (i == 2) ? 8'h03 : 8'h02, "status_wake");
    end
    @(posedge clk);
    watchdog_clear_instr <= 1'b1;
    @(posedge clk);
    watchdog_clear_instr <= 1'b0;
    rd(omc_pkg::ADDR_PWR_STATUS, 8'hFF, 8'h00, "status_clear");
    $display("test halt done");
    for (int d = 0; d < 8; d++) begin
      wr(omc_pkg::ADDR_CLOCK_MODE, {d[2:0], 5'h00});
      wait_lvl(1, d > 1);
      if (d < 2) rd(omc_pkg::ADDR_CLOCK_MODE, 8'h08, 8'h08, "low_ready");
      rd(omc_pkg::ADDR_CLK_STATUS, 8'hFF, (d > 1) ? 8'(omc_pkg::OMC_NORMAL) : 8'(omc_pkg::OMC_SLOW),
         "clock_mode");
    end
    wr(omc_pkg::ADDR_CLOCK_MODE, 8'h01);
    rd(omc_pkg::ADDR_CLOCK_MODE, 8'hE7, 8'h05, "high_ready");
    $display("test clock done");
    results();
  end
endmodule // omc_mode_ctrl_tb_top
`default_nettype wire
